// ---- rtl/pes_sequencer.sv ----
// The APB register port and the register offsets were left to the implementer.
`default_nettype none
// How it works
// - 8-bit external mode shows one to three 8-bit patterns per input frame.
// - Dark and exposure intervals latched at frame start, same for all patterns.
// - Leftover frame time becomes dark fill after the last pattern.
// - Selected illuminator lit only during exposure, dark otherwise.
// - Frame trigger is active high and lasts at least 20 us.
// - External modes fire frame trigger a programmed delay after vsync.
// - Pattern strobe stays high through every exposure.
// - Pattern strobe delay counted from each pattern start, shared per frame.
// - 1-bit mode makes each of 24 pixel bits its own pattern.
// - Counters are wide enough for 1440 Hz binary pattern slots.
// - One illuminator serves every pattern of a 1-bit frame.
// - Internal mode outputs one stored row value for the whole array.
// - Free-running internal mode makes its own frame sync.
// - Load command copies stored image into display memory, then displays.
// - Free-running frame trigger delay counted from internal frame sync.
// - Internal frame length follows the control pattern count, up to 16.
// - Trigger-in mode raises pattern ready when a trigger can be taken.
// - Trigger-in mode fires frame trigger a delay after accepted trigger.
// - Pixel word splits into one to three 8-bit patterns or one to 24 1-bit patterns.
// - Advance input acts only in internal trigger-in mode, not in free-running mode.
module pes_sequencer (
    input  wire logic                        SYS_CLK,
    input  wire logic                        NRST,
    input  wire logic                        PSEL,
    input  wire logic                        PENABLE,
    input  wire logic                        PWRITE,
    input  wire logic [7:0]                  PADDR,
    input  wire logic [31:0]                 PWDATA,
    output logic      [31:0]                 PRDATA,
    output logic                             PREADY,
    output logic                             PSLVERR,
    input  wire logic                        VSYNC_IN,
    input  wire logic [pes_pkg::PIX_W-1:0]   PIXEL_BUS,
    input  wire logic                        EXTERNAL_ADVANCE_INPUT,
    output logic                             FRAME_TRIGGER_OUT,
    output logic                             PATTERN_EXPOSURE_STROBE,
    output logic                             PATTERN_READY,
    output logic      [2:0]                  ILLUM_RGB,
    output logic      [pes_pkg::PAT_W-1:0]   PATTERN_DATA
);
    // ---------------------------------------------------------------
    // Register bus
    // ---------------------------------------------------------------
    logic [31:0]                ctrl;
    logic [pes_pkg::TW-1:0]     pre_reg;
    logic [pes_pkg::TW-1:0]     expo_reg;
    logic [pes_pkg::TW-1:0]     post_reg;
    logic [pes_pkg::TW-1:0]     ftd_reg;
    logic [pes_pkg::TW-1:0]     ptd_reg;
    logic                       overrun;
    logic [pes_pkg::PAT_W-1:0]  image_mem [pes_pkg::MEM_DEPTH];
    logic [pes_pkg::PAT_W-1:0]  disp_mem  [pes_pkg::MEM_DEPTH];
    pes_pkg::pes_state_type     state;
    logic [4:0]                 idx;

    wire       access   = PSEL & PENABLE;
    wire       wr       = access & PWRITE;
    wire       hit_img  = (PADDR & pes_pkg::IMAGE_MASK) == pes_pkg::IMAGE_BASE;
    wire [3:0] img_a    = PADDR[5:2];
    wire       hit_ctrl = PADDR == pes_pkg::CTRL_ADDR;
    wire       hit_pre  = PADDR == pes_pkg::PRE_DARK_ADDR;
    wire       hit_expo = PADDR == pes_pkg::EXPOSURE_ADDR;
    wire       hit_post = PADDR == pes_pkg::POST_DARK_ADDR;
    wire       hit_ftd  = PADDR == pes_pkg::FT_DELAY_ADDR;
    wire       hit_ptd  = PADDR == pes_pkg::PT_DELAY_ADDR;
    wire       hit_stat = PADDR == pes_pkg::STATUS_ADDR;
    wire       mapped   = hit_ctrl | hit_pre | hit_expo | hit_post | hit_ftd | hit_ptd | hit_stat | hit_img;
    wire       wr_ctrl  = wr & hit_ctrl;
    wire       load_cmd = wr_ctrl & PWDATA[pes_pkg::LOAD_BIT];
    wire       ovr_clr  = wr & hit_stat & PWDATA[pes_pkg::OVR_BIT];
    wire [31:0] status_word = {22'h0, PATTERN_READY, overrun, idx, state};

    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~mapped;
    assign PRDATA  = ~access         ? 32'h0 :
                     hit_ctrl        ? {1'b0, ctrl[30:0]} :
                     hit_pre         ? {8'h0, pre_reg} :
                     hit_expo        ? {8'h0, expo_reg} :
                     hit_post        ? {8'h0, post_reg} :
                     hit_ftd         ? {8'h0, ftd_reg} :
                     hit_ptd         ? {8'h0, ptd_reg} :
                     hit_stat        ? status_word :
                     hit_img         ? {24'h0, image_mem[img_a]} : 32'h0;

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl     <= pes_pkg::CTRL_RESET;
            pre_reg  <= '0;
            expo_reg <= '0;
            post_reg <= '0;
            ftd_reg  <= '0;
            ptd_reg  <= '0;
        end else if (wr) begin
            if (hit_ctrl) ctrl     <= {1'b0, PWDATA[30:0]};
            if (hit_pre)  pre_reg  <= PWDATA[pes_pkg::TW-1:0];
            if (hit_expo) expo_reg <= PWDATA[pes_pkg::TW-1:0];
            if (hit_post) post_reg <= PWDATA[pes_pkg::TW-1:0];
            if (hit_ftd)  ftd_reg  <= PWDATA[pes_pkg::TW-1:0];
            if (hit_ptd)  ptd_reg  <= PWDATA[pes_pkg::TW-1:0];
        end
    end

    // Image store is not reset; it stands in for the flash contents
    always_ff @(posedge SYS_CLK) begin
        if (wr & hit_img) image_mem[img_a] <= PWDATA[pes_pkg::PAT_W-1:0];
    end

    // ---------------------------------------------------------------
    // Configuration decode
    // ---------------------------------------------------------------
    wire [1:0] mode_raw  = ctrl[pes_pkg::MODE_LSB +: 2];
    wire       mode_ext8 = mode_raw == pes_pkg::MODE_EXT8;
    wire       mode_ext1 = mode_raw == pes_pkg::MODE_EXT1;
    wire       mode_int  = mode_raw == pes_pkg::MODE_INT;
    wire       mode_ext  = mode_ext8 | mode_ext1;
    wire       trig_mode = mode_int & ctrl[pes_pkg::TRIG_BIT];
    wire       free_mode = mode_int & ~ctrl[pes_pkg::TRIG_BIT];
    wire [4:0] cnt_raw   = ctrl[pes_pkg::COUNT_LSB +: 5];
    wire [4:0] cnt_max   = mode_ext8 ? pes_pkg::MAX_8BIT : mode_ext1 ? pes_pkg::MAX_1BIT : pes_pkg::MAX_INT;
    // Zero means one; oversize counts clamp instead of reading beyond the word
    wire [4:0] cnt_eff   = (cnt_raw == 5'h00) ? 5'h01 : (cnt_raw > cnt_max) ? cnt_max : cnt_raw;
    wire [1:0] illum_sel = ctrl[pes_pkg::ILLUM_LSB +: 2];
    wire [2:0] illum_hot = (illum_sel == 2'h0) ? 3'b001 : (illum_sel == 2'h1) ? 3'b010 : 3'b100;

    // ---------------------------------------------------------------
    // Frame start events
    // ---------------------------------------------------------------
    logic                   vsync_d;
    logic                   adv_d;
    logic [pes_pkg::TW-1:0] tcnt;
    logic [pes_pkg::TW-1:0] lat_pre;
    logic [pes_pkg::TW-1:0] lat_expo;
    logic [pes_pkg::TW-1:0] lat_post;
    logic [pes_pkg::TW-1:0] lat_ptd;
    logic [4:0]             lat_cnt;
    logic [pes_pkg::PIX_W-1:0] lat_pix;
    logic [pes_pkg::MEM_AW:0]  load_cnt;

    wire vs_rise   = VSYNC_IN & ~vsync_d;
    wire adv_rise  = EXTERNAL_ADVANCE_INPUT & ~adv_d;
    wire running   = (state == pes_pkg::ST_PRE) | (state == pes_pkg::ST_EXPO) | (state == pes_pkg::ST_POST);
    wire waiting   = (state == pes_pkg::ST_WAIT) | (state == pes_pkg::ST_FILL);
    wire [pes_pkg::TW-1:0] cur_len = (state == pes_pkg::ST_PRE)  ? lat_pre :
                                     (state == pes_pkg::ST_EXPO) ? lat_expo : lat_post;
    wire t_done    = (tcnt + 24'h1) >= cur_len;
    wire last_pat  = (idx + 5'h01) >= lat_cnt;
    wire post_end  = (state == pes_pkg::ST_POST) & t_done;
    wire ext_start = mode_ext & vs_rise & (waiting | running);
    wire ready_now = trig_mode & (state == pes_pkg::ST_WAIT);
    wire trig_ok   = ready_now & adv_rise;
    wire free_start = free_mode & ((state == pes_pkg::ST_WAIT) | (post_end & last_pat));
    wire fstart    = ext_start | trig_ok | free_start;
    wire ovr_set   = mode_ext & vs_rise & running;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    pes_pkg::pes_state_type next_state;
    logic [4:0]             next_idx;
    wire [4:0]              idx_wrap = last_pat ? 5'h00 : idx + 5'h01;

    always_comb begin
        next_state = state;
        next_idx   = idx;
        case (state)
            pes_pkg::ST_IDLE: begin
                if (load_cmd) next_state = pes_pkg::ST_LOAD;
                else if (mode_ext) next_state = pes_pkg::ST_WAIT;
            end
            pes_pkg::ST_LOAD: begin
                if (load_cnt == 5'(pes_pkg::MEM_DEPTH - 1)) begin
                    next_state = pes_pkg::ST_WAIT;
                    next_idx   = 5'h00;
                end
            end
            pes_pkg::ST_WAIT, pes_pkg::ST_FILL: begin
                if (fstart) begin
                    next_state = pes_pkg::ST_PRE;
                    next_idx   = trig_mode ? idx : 5'h00;
                end
            end
            pes_pkg::ST_PRE: begin
                if (t_done) next_state = pes_pkg::ST_EXPO;
            end
            pes_pkg::ST_EXPO: begin
                if (t_done) next_state = pes_pkg::ST_POST;
            end
            pes_pkg::ST_POST: begin
                if (t_done) begin
                    if (trig_mode) begin
                        next_state = pes_pkg::ST_WAIT;
                        next_idx   = idx_wrap;
                    end else if (!last_pat) begin
                        next_state = pes_pkg::ST_PRE;
                        next_idx   = idx + 5'h01;
                    end else if (free_mode) begin
                        next_state = pes_pkg::ST_PRE;
                        next_idx   = 5'h00;
                    end else begin
                        next_state = pes_pkg::ST_FILL;
                    end
                end
            end
            default: next_state = pes_pkg::ST_IDLE;
        endcase
        // An early vsync restarts the frame; the host broke its budget
        if (ext_start && running) begin
            next_state = pes_pkg::ST_PRE;
            next_idx   = 5'h00;
        end
        if (mode_raw == pes_pkg::MODE_OFF || (load_cmd && state != pes_pkg::ST_LOAD)) begin
            next_state = load_cmd ? pes_pkg::ST_LOAD : pes_pkg::ST_IDLE;
            next_idx   = 5'h00;
        end
    end

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            state    <= pes_pkg::ST_IDLE;
            idx      <= 5'h00;
            vsync_d  <= 1'b0;
            adv_d    <= 1'b0;
            tcnt     <= '0;
            overrun  <= 1'b0;
            load_cnt <= '0;
        end else begin
            state    <= next_state;
            idx      <= next_idx;
            vsync_d  <= VSYNC_IN;
            adv_d    <= EXTERNAL_ADVANCE_INPUT;
            tcnt     <= (next_state != state || next_idx != idx) ? '0 : tcnt + 24'h1;
            overrun  <= ovr_set | (overrun & ~ovr_clr);
            load_cnt <= (state == pes_pkg::ST_LOAD) ? load_cnt + 5'h01 : '0;
        end
    end

    // Intervals frozen per frame so a mid-frame write cannot skew patterns
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            lat_pre  <= '0;
            lat_expo <= '0;
            lat_post <= '0;
            lat_ptd  <= '0;
            lat_cnt  <= 5'h01;
            lat_pix  <= '0;
        end else if (fstart) begin
            lat_pre  <= pre_reg;
            lat_expo <= expo_reg;
            lat_post <= post_reg;
            lat_ptd  <= ptd_reg;
            lat_cnt  <= cnt_eff;
            lat_pix  <= PIXEL_BUS;
        end
    end

    // Display memory copy, one entry per cycle
    always_ff @(posedge SYS_CLK) begin
        if (state == pes_pkg::ST_LOAD) disp_mem[load_cnt[pes_pkg::MEM_AW-1:0]] <= image_mem[load_cnt[pes_pkg::MEM_AW-1:0]];
    end

    // ---------------------------------------------------------------
    // Pattern data select
    // ---------------------------------------------------------------
    wire [pes_pkg::PAT_W-1:0] bit_pats [pes_pkg::PIX_W];
    genvar g;
    generate
        for (g = 0; g < pes_pkg::PIX_W; g++) begin : g_bits
            assign bit_pats[g] = {pes_pkg::PAT_W{lat_pix[g]}};
        end
    endgenerate
    wire [1:0] slice = idx[1:0];
    wire [pes_pkg::PAT_W-1:0] byte_pat = lat_pix[slice*pes_pkg::PAT_W +: pes_pkg::PAT_W];
    wire [pes_pkg::PAT_W-1:0] sel_pat  = mode_ext8 ? byte_pat :
                                          mode_ext1 ? bit_pats[idx] :
                                          disp_mem[idx[pes_pkg::MEM_AW-1:0]];

    // ---------------------------------------------------------------
    // Outputs and triggers
    // ---------------------------------------------------------------
    logic                   ft_arm;
    logic [pes_pkg::TW-1:0] ft_cnt;
    logic [11:0]            pw_cnt;
    wire ft_fire = ft_arm & (ft_cnt >= ftd_reg);

    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ft_arm                  <= 1'b0;
            ft_cnt                  <= '0;
            pw_cnt                  <= '0;
            FRAME_TRIGGER_OUT       <= 1'b0;
            PATTERN_EXPOSURE_STROBE <= 1'b0;
            ILLUM_RGB               <= 3'b000;
            PATTERN_DATA            <= '0;
            PATTERN_READY           <= 1'b0;
        end else begin
            ft_arm  <= fstart | (ft_arm & ~ft_fire);
            ft_cnt  <= fstart ? '0 : ft_cnt + 24'h1;
            // Pulse width fixed at the minimum; frames shorter than it merge pulses
            pw_cnt  <= ft_fire ? pes_pkg::FT_PULSE_CYC : (pw_cnt != 12'h0) ? pw_cnt - 12'h1 : pw_cnt;
            FRAME_TRIGGER_OUT <= ft_fire | (pw_cnt > 12'h1);
            PATTERN_EXPOSURE_STROBE <= (state == pes_pkg::ST_EXPO) |
                                       ((state == pes_pkg::ST_PRE) & (tcnt >= lat_ptd));
            ILLUM_RGB     <= (state == pes_pkg::ST_EXPO) ? illum_hot : 3'b000;
            PATTERN_DATA  <= running ? sel_pat : '0;
            // Control write may leave trigger mode; drop ready until the new mode is seen
            PATTERN_READY <= (next_state == pes_pkg::ST_WAIT) & trig_mode & ~trig_ok & ~wr_ctrl;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    logic [11:0] ft_hi;
    always_ff @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) ft_hi <= '0;
        else ft_hi <= FRAME_TRIGGER_OUT ? ((ft_hi == 12'hFFF) ? ft_hi : ft_hi + 12'h1) : 12'h0;
    end

    property p_dark_off;
        @(posedge SYS_CLK) disable iff (!NRST) (state != pes_pkg::ST_EXPO) |=> (ILLUM_RGB == 3'b000);
    endproperty
    a_dark_off: assert property (p_dark_off) else $error("light on outside exposure");

    property p_light_on;
        @(posedge SYS_CLK) disable iff (!NRST) (state == pes_pkg::ST_EXPO) |=> (ILLUM_RGB == $past(illum_hot)) && $onehot(ILLUM_RGB);
    endproperty
    a_light_on: assert property (p_light_on) else $error("wrong illuminator in exposure");

    property p_strobe_cover;
        @(posedge SYS_CLK) disable iff (!NRST) (state == pes_pkg::ST_EXPO) |=> PATTERN_EXPOSURE_STROBE && ILLUM_RGB != 3'b000;
    endproperty
    a_strobe_cover: assert property (p_strobe_cover) else $error("strobe low during exposure");

    property p_ft_width;
        @(posedge SYS_CLK) disable iff (!NRST) $fell(FRAME_TRIGGER_OUT) |-> (ft_hi >= pes_pkg::FT_PULSE_CYC);
    endproperty
    a_ft_width: assert property (p_ft_width) else $error("frame trigger pulse too short");

    property p_ready_wait;
        @(posedge SYS_CLK) disable iff (!NRST) PATTERN_READY |-> (state == pes_pkg::ST_WAIT) && trig_mode;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready outside trigger wait");

    property p_ready_drop;
        @(posedge SYS_CLK) disable iff (!NRST) trig_ok |=> !PATTERN_READY && (state == pes_pkg::ST_PRE || !trig_mode);
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("ready held after trigger");

    property p_ignore_adv;
        @(posedge SYS_CLK) disable iff (!NRST) (trig_mode && running && adv_rise && !wr_ctrl && !t_done) |=> $stable(idx) && running;
    endproperty
    a_ignore_adv: assert property (p_ignore_adv) else $error("trigger taken while not ready");

    property p_fill_after;
        @(posedge SYS_CLK) disable iff (!NRST) (mode_ext && post_end && last_pat && !vs_rise && !wr_ctrl) |=> (state == pes_pkg::ST_FILL);
    endproperty
    a_fill_after: assert property (p_fill_after) else $error("no dark fill after last pattern");

    property p_frozen;
        @(posedge SYS_CLK) disable iff (!NRST) (running && !fstart) |=> $stable(lat_pre) && $stable(lat_expo) && $stable(lat_post);
    endproperty
    a_frozen: assert property (p_frozen) else $error("intervals changed mid frame");

    property p_ft_delay;
        @(posedge SYS_CLK) disable iff (!NRST) (fstart && ftd_reg == 24'h0 && !wr) |=> ##1 FRAME_TRIGGER_OUT;
    endproperty
    a_ft_delay: assert property (p_ft_delay) else $error("frame trigger missing after start");
endmodule : pes_sequencer
`default_nettype wire

// ---- rtl/pes_pkg.sv ----
`default_nettype none
package pes_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR      = 8'h00;
    localparam logic [7:0] PRE_DARK_ADDR  = 8'h04;
    localparam logic [7:0] EXPOSURE_ADDR  = 8'h08;
    localparam logic [7:0] POST_DARK_ADDR = 8'h0C;
    localparam logic [7:0] FT_DELAY_ADDR  = 8'h10;
    localparam logic [7:0] PT_DELAY_ADDR  = 8'h14;
    localparam logic [7:0] STATUS_ADDR    = 8'h18;
    localparam logic [7:0] IMAGE_BASE     = 8'h40;
    localparam logic [7:0] IMAGE_MASK     = 8'hC0;
    // ---------------------------------------------------------------
    // Fields
    // ---------------------------------------------------------------
    localparam int MODE_LSB    = 0;
    localparam int TRIG_BIT    = 2;
    localparam int COUNT_LSB   = 3;
    localparam int ILLUM_LSB   = 8;
    localparam int LOAD_BIT    = 31;
    localparam int OVR_BIT     = 8;
    localparam int READY_BIT   = 9;
    localparam int IDX_LSB     = 3;
    localparam int TW          = 24;
    localparam int MEM_DEPTH   = 16;
    localparam int MEM_AW      = 4;
    localparam int PIX_W       = 24;
    localparam int PAT_W       = 8;
    localparam logic [4:0] MAX_8BIT  = 5'h03;
    localparam logic [4:0] MAX_1BIT  = 5'h18;
    localparam logic [4:0] MAX_INT   = 5'h10;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0208;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int FT_MIN_PULSE_US  = 20;
    localparam logic [11:0] FT_PULSE_CYC = 12'(FT_MIN_PULSE_US * CLK_MHZ);
    localparam int MAX_1BIT_RATE_HZ = 1440;
    localparam int MIN_1BIT_SLOT_CYC = (CLK_MHZ * 1000000) / MAX_1BIT_RATE_HZ;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OFF  = 2'b00,
        MODE_EXT8 = 2'b01,
        MODE_EXT1 = 2'b10,
        MODE_INT  = 2'b11
    } pes_mode_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_WAIT = 3'b010,
        ST_PRE  = 3'b011,
        ST_EXPO = 3'b100,
        ST_POST = 3'b101,
        ST_FILL = 3'b110
    } pes_state_type;
endpackage : pes_pkg
`default_nettype wire

// ---- verif/pes_host_model.sv ----
`default_nettype none
module pes_host_model (
    input  wire logic        clk,
    output logic             vsync,
    output logic [23:0]      pixel,
    output logic             advance
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        vsync = 1'b0;
        pixel = 24'h000000;
        advance = 1'b0;
    end
    // Frame start, word held over the sampling cycle
    task automatic frame(input logic [23:0] pix);
        @(posedge clk);
        vsync <= 1'b1;
        pixel <= pix;
        repeat (4) @(posedge clk);
        vsync <= 1'b0;
        pixel <= ~pix; // Released bus must not look like the last word
    endtask : frame
    task automatic pulse_advance();
        @(posedge clk);
        advance <= 1'b1;
        repeat (2) @(posedge clk);
        advance <= 1'b0;
    endtask : pulse_advance
endmodule : pes_host_model
`default_nettype wire

// ---- verif/pattern_exposure_sequencer_tb_top.sv ----
`default_nettype none
module pattern_exposure_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, psel, pen, pwr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, vs, adv, ft, st, rdy, err;
    logic [23:0] pix;
    logic [2:0] il;
    logic [7:0] pd;
    int n_fail = 0;
    int checks = 0;
    pes_sequencer uut (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .VSYNC_IN(vs), .PIXEL_BUS(pix),
        .EXTERNAL_ADVANCE_INPUT(adv), .FRAME_TRIGGER_OUT(ft), .PATTERN_EXPOSURE_STROBE(st),
        .PATTERN_READY(rdy), .ILLUM_RGB(il), .PATTERN_DATA(pd));
    pes_host_model host (.clk(clk), .vsync(vs), .pixel(pix), .advance(adv));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input bit ok, input string m);
        checks++;
        if (!ok) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic set_times(input logic [31:0] e);
        apb(1'b1, pes_pkg::PRE_DARK_ADDR, 32'h1);
        apb(1'b1, pes_pkg::EXPOSURE_ADDR, e);
        apb(1'b1, pes_pkg::POST_DARK_ADDR, 32'h1);
        apb(1'b1, pes_pkg::FT_DELAY_ADDR, 32'h5);
        apb(1'b1, pes_pkg::PT_DELAY_ADDR, 32'h0);
    endtask : set_times
    // Counts lit patterns over a fixed window, judging data and lamp at each start
    task automatic grab(input int n, input logic [23:0] p, input bit one, input logic [2:0] lamp);
        int k;
        logic [2:0] pv;
        k = 0;
        pv = 3'b000;
        repeat (400) begin
            @(posedge clk);
            if (il !== 3'b000 && st !== 1'b1) check(0, "lamp lit outside strobe");
            if (il !== 3'b000 && pv === 3'b000 && k < 24) begin
                check(pd === (one ? {8{p[k]}} : p[8*k+:8]), "pattern data");
                check(il === lamp, "illuminator");
                k++;
            end
            pv = il;
        end
        check(k == n, "pattern count");
    endtask : grab
    task automatic ft_check();
        int c;
        c = 0;
        while (ft !== 1'b1 && c < 60) begin
            @(posedge clk);
            c++;
        end
        check(c >= 6 && c <= 12, "frame trigger delay");
        c = 0;
        while (ft === 1'b1 && c < 3000) begin
            @(posedge clk);
            c++;
        end
        check(c >= int'(pes_pkg::FT_PULSE_CYC), "frame trigger width");
    endtask : ft_check
    task automatic t_reset_map();
        apb(1'b0, pes_pkg::CTRL_ADDR, 32'h0);
        check(rd === pes_pkg::CTRL_RESET, "control reset value");
        apb(1'b0, 8'h3C, 32'h0);
        check(err === 1'b1 && rd === 32'h0, "unmapped access");
    endtask : t_reset_map
    task automatic t_ext(input logic [31:0] ctl, input int n, input bit one, input logic [2:0] lamp);
        set_times(32'h2);
        apb(1'b1, pes_pkg::CTRL_ADDR, ctl);
        fork
            host.frame(24'hA5C30F);
            grab(n, 24'hA5C30F, one, lamp);
            ft_check();
        join
    endtask : t_ext
    task automatic t_trigger();
        set_times(32'h14);
        apb(1'b1, 8'h40, 32'h3C);
        apb(1'b1, 8'h44, 32'hC3);
        apb(1'b1, pes_pkg::CTRL_ADDR, 32'h8000_0017);
        repeat (200) if (rdy !== 1'b1) @(posedge clk);
        check(rdy === 1'b1, "ready after load");
        fork
            begin
                host.pulse_advance();
                repeat (3) @(posedge clk);
                check(rdy === 1'b0, "ready kept high");
                host.pulse_advance();
            end
            grab(1, 24'h00003C, 1'b0, 3'b001);
            ft_check();
        join
        fork
            host.pulse_advance();
            grab(1, 24'h0000C3, 1'b0, 3'b001);
        join
    endtask : t_trigger
    // Free run: lamp starts one pattern apart with no sync input, strobe leads lamp
    task automatic t_free();
        int n;
        int r;
        int f;
        int i;
        logic [2:0] pv;
        logic ps;
        logic pps;
        n = 0;
        r = 0;
        f = -1;
        pv = 3'b000;
        ps = 1'b0;
        pps = 1'b0;
        while (ft === 1'b1) @(posedge clk);
        set_times(32'h2);
        apb(1'b1, pes_pkg::PRE_DARK_ADDR, 32'h3);
        apb(1'b1, pes_pkg::FT_DELAY_ADDR, 32'h0);
        apb(1'b1, pes_pkg::PT_DELAY_ADDR, 32'h2);
        apb(1'b1, pes_pkg::CTRL_ADDR, 32'h8000_0113);
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (ft === 1'b1 && f < 0) f = i;
            if (il !== 3'b000 && pv === 3'b000) begin
                check(ps === 1'b1 && pps === 1'b0, "strobe delay");
                check(pd === (n[0] ? 8'hC3 : 8'h3C) && il === 3'b010, "free pattern");
                if (n == 0) check(i - f == 3, "free frame trigger delay");
                else check(i - r == 6, "internal frame pacing");
                r = i;
                n++;
            end
            pps = ps;
            ps = st;
            pv = il;
        end
        check(n >= 29, "free run stalled");
        apb(1'b1, pes_pkg::CTRL_ADDR, 32'h0);
        apb(1'b0, pes_pkg::STATUS_ADDR, 32'h0);
        check(rd[2:0] === 3'h0 && rd[9] === 1'b0 && pd === 8'h00 && il === 3'b000, "mode off");
    endtask : t_free
    task automatic end_of_test();
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    initial begin
        {nrst, psel, pen, pwr, paddr, pwdata} = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_reset_map();
        t_ext(32'h0000_0219, 3, 1'b0, 3'b100);
        t_ext(32'h0000_01C2, 24, 1'b1, 3'b010);
        t_trigger();
        t_free();
        end_of_test();
    end
    initial begin
        #500000;
        n_fail++;
        end_of_test();
    end
endmodule : pattern_exposure_sequencer_tb_top
`default_nettype wire
